// *** shared/gci_defs.svh ***
`ifndef GCI_DEFS_SVH
`define GCI_DEFS_SVH

// ---------------------------------------------------------------
// sizes
// ---------------------------------------------------------------
`define GCI_NUM_IRQ      4
`define GCI_MAP_W        16

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define GCI_CLK_NS       20
`define GCI_INH_LAT_NS   10000
`define GCI_OFF_LAT_US   1000
`define GCI_CB_PULSE_US  1000
`define GCI_INH_CYC      ((`GCI_INH_LAT_NS) / (`GCI_CLK_NS))
`define GCI_OFF_CYC      ((`GCI_OFF_LAT_US * 1000) / (`GCI_CLK_NS))
`define GCI_CB_CYC       ((`GCI_CB_PULSE_US * 1000) / (`GCI_CLK_NS))

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define GCI_PEND_RST     4'hF
`define GCI_GRP_ON_RST   4'h0
`define GCI_ALL_GRP      4'hF
`define GCI_NO_GRP       4'h0
`define GCI_PIN_RST      11'h7FF

`endif

// *** shared/gci_pkg.sv ***
package gci_pkg;

    // sequencer states, one-hot
    typedef enum logic [1:0] {
        GCI_IDLE = 2'h1,
        GCI_BUSY = 2'h2
    } gci_seq_t;

    // per-input function select
    typedef enum logic {
        GCI_MODE_INHIBIT = 1'h0,
        GCI_MODE_TRIGGER = 1'h1
    } gci_irq_mode_t;

endpackage

// *** shared/gci_tmr_if.sv ***
`timescale 1ns/1ps
interface gci_tmr_if #(
    parameter int W = 16
);
    logic         start;
    logic [W-1:0] len;
    logic         busy;
    logic         done;

    modport ctl (output start, output len, input busy, input done);
    modport tmr (input start, input len, output busy, output done);
endinterface

// *** core/gci_sync3.sv ***
`timescale 1ns/1ps
module gci_sync3 #(
    parameter int         W   = 11,
    parameter logic [W-1:0] RST = '1
) (
    input  wire logic         clk_i,   // system clock
    input  wire logic         rstn_i,  // async reset, active low
    input  wire logic [W-1:0] d_i,     // raw pin levels
    output logic      [W-1:0] q_o      // filtered levels
);
    logic [W-1:0] s1_r, s2_r, s3_r, q_r;
    logic [W-1:0] q_nxt;

    // ---------------------------------------------------------------
    // accept a level once stages two and three agree
    // ---------------------------------------------------------------
    always_comb begin
        q_nxt = q_r;
        for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                q_nxt[i] = s3_r[i];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_r <= RST;
            s2_r <= RST;
            s3_r <= RST;
            q_r  <= RST;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r  <= q_nxt;
        end
    end

    assign q_o = q_r;
endmodule

// *** core/gci_timer.sv ***
`timescale 1ns/1ps
module gci_timer #(
    parameter int W = 16
) (
    input  wire logic clk_i,   // system clock
    input  wire logic rstn_i,  // async reset, active low
    gci_tmr_if.tmr    t        // start/length in, busy/done out
);
    logic [W-1:0] cnt_r, cnt_nxt;
    logic         busy_r, busy_nxt;
    logic         done_r, done_nxt;

    // ---------------------------------------------------------------
    // busy for len cycles after start, then one done pulse
    // ---------------------------------------------------------------
    always_comb begin
        cnt_nxt  = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        if (t.start) begin
            cnt_nxt  = W'(t.len - 1'b1);
            busy_nxt = 1'b1;
        end else if (busy_r) begin
            if (cnt_r == '0) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = W'(cnt_r - 1'b1);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r  <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign t.busy = busy_r;
    assign t.done = done_r;
endmodule

// *** core/gci_group_ctl.sv ***
`timescale 1ns/1ps
`include "gci_defs.svh"
module gci_group_ctl #(
    parameter int INH_CYC     = `GCI_INH_CYC,
    parameter int OFF_LAT_CYC = `GCI_OFF_CYC,
    parameter int CB_CYC      = `GCI_CB_CYC
) (
    input  wire logic        clk_i,               // system clock
    input  wire logic        rstn_i,              // async reset, active low
    input  wire logic [3:0]  hotswap_irq_low_i,   // interrupt pins, active low
    input  wire logic        mains_loss_in_low_i, // mains-loss pin, active low
    input  wire logic        system_off_in_low_i, // system-off pin, active low
    input  wire logic        hard_reset_in_low_i, // hard reset pin, active low
    input  wire logic [3:0]  ok_i,                // group line levels
    input  wire logic [3:0]  irq_mode_i,          // 1 trigger, 0 inhibit
    input  wire logic [15:0] inhibit_map_i,       // groups per inhibit input
    input  wire logic        auto_turn_on_i,      // turn on after programming
    input  wire logic [3:0]  grp_turn_on_i,       // host turn-on pulse
    input  wire logic [3:0]  grp_turn_off_i,      // host turn-off pulse
    input  wire logic        front_end_on_req_i,  // host front-end level
    input  wire logic        crowbar_enable_i,    // crowbar armed
    input  wire logic        crowbar_trigger_i,   // crowbar request pulse
    input  wire logic        prog_done_i,         // programming finished
    output logic      [3:0]  ok_o,                // group line drive value
    output logic      [3:0]  ok_oe_o,             // group line pull low
    output logic             prog_start_o,        // start programming pulse
    output logic      [3:0]  prog_groups_o,       // groups to program
    output logic             prog_busy_o,         // programming in flight
    output logic             prog_status_clr_o,   // clear status pulse
    output logic             runtime_save_o,      // save run-time pulse
    output logic             session_drop_o,      // drop host session pulse
    output logic             front_end_on_o,      // front-end enable
    output logic             crowbar_fire_o,      // crowbar pulse
    output logic      [3:0]  grp_on_o,            // group run permission
    output logic      [3:0]  ok_line_low_o        // group line seen low
);
    localparam int INH_W = $clog2(INH_CYC + 1);
    localparam int OFF_W = $clog2(OFF_LAT_CYC + 1);
    localparam int CB_W  = $clog2(CB_CYC + 1);
    localparam int NI    = `GCI_NUM_IRQ;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [10:0] pin_s;
    logic [3:0]  irq_s;
    logic        ml_s, so_s, hr_s;

    gci_sync3 #(
        .W   (11),
        .RST (`GCI_PIN_RST)
    ) u_sync (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .d_i    ({ok_i, hard_reset_in_low_i, system_off_in_low_i, mains_loss_in_low_i, hotswap_irq_low_i}),
        .q_o    (pin_s)
    );

    assign irq_s = pin_s[3:0];
    assign ml_s  = pin_s[4];
    assign so_s  = pin_s[5];
    assign hr_s  = pin_s[6];

    // ---------------------------------------------------------------
    // timers
    // ---------------------------------------------------------------
    gci_tmr_if #(.W(OFF_W)) off_t ();
    gci_tmr_if #(.W(CB_W))  cb_t ();

    gci_timer #(.W(OFF_W)) u_off_tmr (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .t      (off_t)
    );

    gci_timer #(.W(CB_W)) u_cb_tmr (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .t      (cb_t)
    );

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    gci_pkg::gci_seq_t seq_r, seq_nxt;
    logic [INH_W-1:0]  inh_cnt_r [NI];
    logic [INH_W-1:0]  inh_cnt_nxt [NI];
    logic [3:0]        irq_prev_r, pend_r, pend_nxt, pgrp_r, pgrp_nxt;
    logic [3:0]        abort_r, abort_nxt, grp_on_r, grp_on_nxt;
    logic [3:0]        pull_r, pull_nxt, inh_grp;
    logic              off_prev_r, off_hold_r, off_hold_nxt, hr_prev_r;
    logic              start_r, start_nxt, busy_r, clr_r, clr_nxt;
    logic              save_r, save_nxt, drop_r, drop_nxt;
    logic              fe_r, cb_r;
    logic [3:0]        drv_r, low_r;
    logic              off_now, hr_now, off_fall, off_rise, hr_fall, hr_rise;
    logic [3:0]        trig_fall, trig_rise, inh_sel;

    assign off_now   = ~(ml_s & so_s);
    assign hr_now    = ~hr_s;
    assign off_fall  = off_now & ~off_prev_r;
    assign off_rise  = ~off_now & off_prev_r;
    assign hr_fall   = hr_now & ~hr_prev_r;
    assign hr_rise   = ~hr_now & hr_prev_r;

    assign inh_sel   = ~irq_mode_i;
    // input k maps to group k
    assign trig_fall = irq_mode_i & irq_prev_r & ~irq_s;
    assign trig_rise = irq_mode_i & ~irq_prev_r & irq_s;

    assign off_t.start = off_fall;
    assign off_t.len   = OFF_W'(OFF_LAT_CYC);
    assign cb_t.start  = crowbar_enable_i & crowbar_trigger_i & ~cb_t.busy;
    assign cb_t.len    = CB_W'(CB_CYC);

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        seq_nxt      = seq_r;
        pend_nxt     = pend_r;
        pgrp_nxt     = pgrp_r;
        abort_nxt    = abort_r;
        grp_on_nxt   = grp_on_r;
        off_hold_nxt = off_hold_r;
        start_nxt    = 1'b0;
        clr_nxt      = 1'b0;
        save_nxt     = 1'b0;
        drop_nxt     = 1'b0;
        inh_grp      = `GCI_NO_GRP;

        for (int k = 0; k < NI; k++) begin
            if (inh_sel[k] && !irq_s[k]) begin
                inh_cnt_nxt[k] = (inh_cnt_r[k] == INH_W'(INH_CYC)) ? inh_cnt_r[k] : INH_W'(inh_cnt_r[k] + 1'b1);
            end else begin
                inh_cnt_nxt[k] = '0;
            end
            if (inh_cnt_nxt[k] == INH_W'(INH_CYC)) begin
                inh_grp = inh_grp | inhibit_map_i[k*4 +: 4];
            end
        end

        if (off_fall) begin
            clr_nxt   = 1'b1;
            save_nxt  = 1'b1;
            abort_nxt = `GCI_ALL_GRP;
        end
        if (off_t.done && off_now) begin
            off_hold_nxt = 1'b1;
        end
        if (off_rise) begin
            off_hold_nxt = 1'b0;
            grp_on_nxt   = `GCI_NO_GRP;
            pend_nxt     = `GCI_ALL_GRP;
        end

        pend_nxt = pend_nxt | trig_fall;
        if (trig_rise != `GCI_NO_GRP) begin
            clr_nxt    = 1'b1;
            grp_on_nxt = grp_on_nxt & ~trig_rise;
            pend_nxt   = pend_nxt & ~trig_rise;
            abort_nxt  = abort_nxt | trig_rise;
        end

        // host commands, turn-off wins over turn-on in the same cycle
        grp_on_nxt = (grp_on_nxt | grp_turn_on_i) & ~grp_turn_off_i;

        unique case (seq_r)
            gci_pkg::GCI_IDLE: begin
                if (pend_nxt != `GCI_NO_GRP && !off_now && !hr_now) begin
                    start_nxt = 1'b1;
                    pgrp_nxt  = pend_nxt;
                    pend_nxt  = `GCI_NO_GRP;
                    abort_nxt = `GCI_NO_GRP;
                    seq_nxt   = gci_pkg::GCI_BUSY;
                end
            end
            gci_pkg::GCI_BUSY: begin
                if (prog_done_i) begin
                    seq_nxt = gci_pkg::GCI_IDLE;
                    if (auto_turn_on_i) begin
                        grp_on_nxt = grp_on_nxt | (pgrp_r & ~abort_nxt);
                    end
                end
            end
        endcase

        if (hr_now) begin
            grp_on_nxt   = `GCI_NO_GRP;
            pend_nxt     = `GCI_ALL_GRP;
            abort_nxt    = `GCI_ALL_GRP;
            off_hold_nxt = 1'b0;
            start_nxt    = 1'b0;
            seq_nxt      = gci_pkg::GCI_IDLE;
        end
        drop_nxt = hr_fall;
        if (hr_rise) begin
            clr_nxt = 1'b1;
        end

        pull_nxt = ~grp_on_nxt | inh_grp | {4{off_hold_nxt | hr_now}};
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            seq_r      <= gci_pkg::GCI_IDLE;
            inh_cnt_r  <= '{default: '0};
            irq_prev_r <= `GCI_ALL_GRP;
            pend_r     <= `GCI_PEND_RST;
            pgrp_r     <= `GCI_NO_GRP;
            abort_r    <= `GCI_NO_GRP;
            grp_on_r   <= `GCI_GRP_ON_RST;
            pull_r     <= `GCI_ALL_GRP;
            off_prev_r <= 1'b0;
            off_hold_r <= 1'b0;
            hr_prev_r  <= 1'b0;
            start_r    <= 1'b0;
            busy_r     <= 1'b0;
            clr_r      <= 1'b0;
            save_r     <= 1'b0;
            drop_r     <= 1'b0;
            fe_r       <= 1'b0;
            cb_r       <= 1'b0;
            drv_r      <= `GCI_NO_GRP;
            low_r      <= `GCI_NO_GRP;
        end else begin
            seq_r      <= seq_nxt;
            inh_cnt_r  <= inh_cnt_nxt;
            irq_prev_r <= irq_s;
            pend_r     <= pend_nxt;
            pgrp_r     <= pgrp_nxt;
            abort_r    <= abort_nxt;
            grp_on_r   <= grp_on_nxt;
            pull_r     <= pull_nxt;
            off_prev_r <= off_now;
            off_hold_r <= off_hold_nxt;
            hr_prev_r  <= hr_now;
            start_r    <= start_nxt;
            busy_r     <= (seq_nxt == gci_pkg::GCI_BUSY);
            clr_r      <= clr_nxt;
            save_r     <= save_nxt;
            drop_r     <= drop_nxt;
            fe_r       <= front_end_on_req_i;
            cb_r       <= cb_t.busy;
            drv_r      <= ~pull_nxt;
            low_r      <= ~pin_s[10:7];
        end
    end

    assign ok_o              = drv_r;
    assign ok_oe_o           = pull_r;
    assign prog_start_o      = start_r;
    assign prog_groups_o     = pgrp_r;
    assign prog_busy_o       = busy_r;
    assign prog_status_clr_o = clr_r;
    assign runtime_save_o    = save_r;
    assign session_drop_o    = drop_r;
    assign front_end_on_o    = fe_r;
    assign crowbar_fire_o    = cb_r;
    assign grp_on_o          = grp_on_r;
    assign ok_line_low_o     = low_r;
endmodule

// *** dv/gci_group_ctl_asserts.sv ***
`timescale 1ns/1ps
module gci_group_ctl_asserts #(
    parameter int INH_CYC     = 8,
    parameter int OFF_LAT_CYC = 20,
    parameter int CB_CYC      = 20
) (
    input wire logic        clk_i,               // clock
    input wire logic        rstn_i,              // reset
    input wire logic [3:0]  hotswap_irq_low_i,   // interrupt pins
    input wire logic        mains_loss_in_low_i, // mains-loss pin
    input wire logic        system_off_in_low_i, // system-off pin
    input wire logic        hard_reset_in_low_i, // hard reset pin
    input wire logic [3:0]  irq_mode_i,          // input modes
    input wire logic [15:0] inhibit_map_i,       // inhibit map
    input wire logic        front_end_on_req_i,  // front-end request
    input wire logic        prog_done_i,         // programming done
    input wire logic [3:0]  ok_o,                // line drive
    input wire logic [3:0]  ok_oe_o,             // line pull
    input wire logic        prog_start_o,        // start pulse
    input wire logic [3:0]  prog_groups_o,       // job groups
    input wire logic        prog_busy_o,         // job running
    input wire logic        prog_status_clr_o,   // clear pulse
    input wire logic        runtime_save_o,      // save pulse
    input wire logic        front_end_on_o,      // front-end enable
    input wire logic        crowbar_fire_o       // crowbar pulse
);
    int         off_cnt_r;
    int         hr_cnt_r;
    int         cb_cnt_r;
    int         inh_cnt_r [4];
    logic [3:0] inh_mask;

    // ------------------------------------------------
    // cycles each cause has been held
    // ------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            off_cnt_r <= 0;
            hr_cnt_r  <= 0;
            cb_cnt_r  <= 0;
            inh_cnt_r <= '{default: 0};
        end else begin
            off_cnt_r <= (!mains_loss_in_low_i || !system_off_in_low_i) ? off_cnt_r + 1 : 0;
            hr_cnt_r  <= !hard_reset_in_low_i ? hr_cnt_r + 1 : 0;
            cb_cnt_r  <= crowbar_fire_o ? cb_cnt_r + 1 : 0;
            for (int k = 0; k < 4; k++)
                inh_cnt_r[k] <= (!hotswap_irq_low_i[k] && !irq_mode_i[k]) ? inh_cnt_r[k] + 1 : 0;
        end
    end

    always_comb begin
        inh_mask = 4'h0;
        for (int k = 0; k < 4; k++)
            if (inh_cnt_r[k] >= INH_CYC + 10)
                inh_mask = inh_mask | inhibit_map_i[4*k +: 4];
    end

    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    a_ok_drive_inv: assert property (ok_o == ~ok_oe_o)
        else $error("line drive differs from pull");
    a_fe_follow: assert property (front_end_on_o == $past(front_end_on_req_i))
        else $error("front-end enable not following request");
    a_cb_exact: assert property ($fell(crowbar_fire_o) |-> cb_cnt_r == CB_CYC)
        else $error("crowbar pulse length wrong");
    a_busy_done: assert property (prog_busy_o && prog_done_i |=> !prog_busy_o)
        else $error("busy not dropped after done");
    a_loss_hold: assert property (off_cnt_r >= OFF_LAT_CYC + 12 |-> ok_oe_o == 4'hF)
        else $error("lines not all pulled on power loss");
    a_no_prog_loss: assert property (off_cnt_r >= 8 |-> !prog_start_o)
        else $error("programming started during power loss");
    a_inh_hold: assert property ((ok_oe_o & inh_mask) == inh_mask)
        else $error("inhibited group line released");
    a_hard_off: assert property (hr_cnt_r >= 8 |-> ok_oe_o == 4'hF)
        else $error("lines not pulled during hard reset");
    a_trig_start: assert property ($fell(hotswap_irq_low_i[3]) && irq_mode_i[3] && !prog_busy_o
        |-> ##[2:10] prog_start_o && prog_groups_o == 4'h8) else $error("trigger did not program its group");
    a_trig_release: assert property ($rose(hotswap_irq_low_i[0]) && irq_mode_i[0]
        |-> ##[2:10] prog_status_clr_o && ok_oe_o[0]) else $error("trigger release missed clear or pull");
    a_save_on_loss: assert property ($fell(mains_loss_in_low_i) && system_off_in_low_i
        |-> ##[2:10] runtime_save_o) else $error("run-time save missing");

    c_crowbar: cover property ($rose(crowbar_fire_o));
    c_save: cover property (runtime_save_o);
    c_prog_end: cover property (prog_busy_o && prog_done_i);
endmodule

// *** dv/gci_pol_model.sv ***
`timescale 1ns/1ps
module gci_pol_model #(
    parameter int DLY = 6
) (
    input  wire logic       clk_i,        // system clock
    input  wire logic       rstn_i,       // reset, active low
    input  wire logic       prog_start_i, // start programming
    input  wire logic [3:0] ok_oe_i,      // manager pulls line
    output logic            prog_done_o,  // programming finished
    output logic      [3:0] ok_lvl_o      // resolved line level
);
    int cnt_r;

    // pulled line low
    // pull-up brings released lines high
    assign ok_lvl_o = ~ok_oe_i;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r       <= 0;
            prog_done_o <= 1'b0;
        end else begin
            prog_done_o <= (cnt_r == 1);
            if (prog_start_i)
                cnt_r <= DLY;
            else if (cnt_r != 0)
                cnt_r <= cnt_r - 1;
        end
    end
endmodule

// *** dv/test_gci_group_ctl.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (a), (e)); end end
`define WAITC(c, lim) begin n = 0; while (!(c) && n < (lim)) begin @(negedge clk_i); n++; end end
`define WATCH(s, sig) begin s = 1'b0; repeat (10) begin @(negedge clk_i); s = s | (sig); end end

module test_gci_group_ctl;
    localparam int INH = 8;
    localparam int OFF = 20;
    localparam int CB  = 20;

    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [3:0]  hotswap_irq_low_i = 4'hF;
    logic        mains_loss_in_low_i = 1'b1;
    logic        system_off_in_low_i = 1'b1;
    logic        hard_reset_in_low_i = 1'b1;
    logic [3:0]  irq_mode_i = 4'h0;
    logic [15:0] inhibit_map_i = 16'h0000;
    logic        auto_turn_on_i = 1'b1;
    logic [3:0]  grp_turn_on_i = 4'h0;
    logic [3:0]  grp_turn_off_i = 4'h0;
    logic        front_end_on_req_i = 1'b0;
    logic        crowbar_enable_i = 1'b0;
    logic        crowbar_trigger_i = 1'b0;
    logic [3:0]  ok_i;
    logic        prog_done_i;
    logic [3:0]  ok_o, ok_oe_o, prog_groups_o, grp_on_o, ok_line_low_o;
    logic        prog_start_o, prog_busy_o, prog_status_clr_o, runtime_save_o;
    logic        session_drop_o, front_end_on_o, crowbar_fire_o;
    int          error_cnt = 0;
    int          checks_done = 0;
    int          n;
    int          cyc = 0;

    gci_group_ctl #(.INH_CYC(INH), .OFF_LAT_CYC(OFF), .CB_CYC(CB)) dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .hotswap_irq_low_i(hotswap_irq_low_i),
        .mains_loss_in_low_i(mains_loss_in_low_i), .system_off_in_low_i(system_off_in_low_i),
        .hard_reset_in_low_i(hard_reset_in_low_i), .ok_i(ok_i), .irq_mode_i(irq_mode_i),
        .inhibit_map_i(inhibit_map_i), .auto_turn_on_i(auto_turn_on_i), .grp_turn_on_i(grp_turn_on_i),
        .grp_turn_off_i(grp_turn_off_i), .front_end_on_req_i(front_end_on_req_i),
        .crowbar_enable_i(crowbar_enable_i),
        .crowbar_trigger_i(crowbar_trigger_i), .prog_done_i(prog_done_i), .ok_o(ok_o), .ok_oe_o(ok_oe_o),
        .prog_start_o(prog_start_o), .prog_groups_o(prog_groups_o), .prog_busy_o(prog_busy_o),
        .prog_status_clr_o(prog_status_clr_o), .runtime_save_o(runtime_save_o),
        .session_drop_o(session_drop_o), .front_end_on_o(front_end_on_o),
        .crowbar_fire_o(crowbar_fire_o), .grp_on_o(grp_on_o), .ok_line_low_o(ok_line_low_o));

    gci_pol_model #(.DLY(6)) u_pol (.clk_i(clk_i), .rstn_i(rstn_i), .prog_start_i(prog_start_o),
        .ok_oe_i(ok_oe_o), .prog_done_o(prog_done_i), .ok_lvl_o(ok_i));

    always #10 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cyc++;
        if (cyc >= 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    // ------------------------------------------------
    // shared steps
    // ------------------------------------------------
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic prog_all(input logic [3:0] grp, input logic [3:0] on);
        `WAITC(prog_start_o, 12)
        `CHK({prog_start_o, prog_busy_o}, 2'h3)
        `CHK(prog_groups_o, grp)
        `WAITC(!prog_busy_o, 20)
        repeat (2) @(negedge clk_i);
        `CHK(grp_on_o & grp, on)
        `CHK(ok_oe_o & grp, ~on & grp)
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_front_end;
        front_end_on_req_i = 1'b1;
        @(negedge clk_i);
        `CHK(front_end_on_o, 1'b1)
        front_end_on_req_i = 1'b0;
        @(negedge clk_i);
        `CHK(front_end_on_o, 1'b0)
    endtask

    task automatic t_inhibit;
        irq_mode_i = 4'h8;
        inhibit_map_i = 16'h0005;
        hotswap_irq_low_i[0] = 1'b0;
        `WAITC(ok_oe_o[0], INH + 20)
        `CHK(n >= INH, 1'b1)
        `CHK(ok_oe_o, 4'h5)
        hotswap_irq_low_i[3] = 1'b0;
        prog_all(4'h8, 4'h8);
        hotswap_irq_low_i[0] = 1'b1;
        `WAITC(ok_oe_o === 4'h0, 12)
        `CHK(ok_oe_o, 4'h0)
        hotswap_irq_low_i[3] = 1'b1;
        `WAITC(ok_oe_o[3], 12)
        `CHK(ok_oe_o, 4'h8)
    endtask

    task automatic t_triggers;
        logic s;
        irq_mode_i = 4'hF;
        for (int k = 0; k < 4; k++) begin
            hotswap_irq_low_i[k] = 1'b0;
            prog_all(4'h1 << k, 4'h1 << k);
            hotswap_irq_low_i[k] = 1'b1;
            `WATCH(s, prog_status_clr_o)
            `CHK(s, 1'b1)
            `CHK(ok_oe_o[k], 1'b1)
        end
    endtask

    task automatic t_hard;
        logic s;
        hard_reset_in_low_i = 1'b0;
        `WATCH(s, session_drop_o)
        `CHK(s, 1'b1)
        `CHK(ok_oe_o, 4'hF)
        `CHK(grp_on_o, 4'h0)
        `CHK(ok_line_low_o, 4'hF)
        hard_reset_in_low_i = 1'b1;
        prog_all(4'hF, 4'hF);
    endtask

    task automatic t_off(input logic sys, input logic auto);
        logic s;
        auto_turn_on_i = auto;
        if (sys)
            system_off_in_low_i = 1'b0;
        else
            mains_loss_in_low_i = 1'b0;
        `WATCH(s, runtime_save_o)
        `CHK(s, 1'b1)
        `CHK(ok_oe_o, 4'h0)
        `CHK(ok_line_low_o, 4'h0)
        `WAITC(ok_oe_o === 4'hF, OFF + 30)
        `CHK(n + 10 >= OFF, 1'b1)
        `CHK(ok_oe_o, 4'hF)
        `WATCH(s, prog_start_o)
        `CHK(s, 1'b0)
        system_off_in_low_i = 1'b1;
        mains_loss_in_low_i = 1'b1;
        prog_all(4'hF, auto ? 4'hF : 4'h0);
        if (!auto) begin
            grp_turn_on_i = 4'hF;
            grp_turn_off_i = 4'h2;
            @(negedge clk_i);
            grp_turn_on_i = 4'h0;
            grp_turn_off_i = 4'h0;
            repeat (2) @(negedge clk_i);
            `CHK(grp_on_o, 4'hD)
            `CHK(ok_oe_o, 4'h2)
            grp_turn_on_i = 4'h2;
            @(negedge clk_i);
            grp_turn_on_i = 4'h0;
            `WAITC(ok_oe_o === 4'h0, 8)
            `CHK(grp_on_o, 4'hF)
        end
    endtask

    task automatic t_crowbar;
        logic s;
        int   hi;
        crowbar_trigger_i = 1'b1;
        @(negedge clk_i);
        crowbar_trigger_i = 1'b0;
        `WATCH(s, crowbar_fire_o)
        `CHK(s, 1'b0)
        crowbar_enable_i = 1'b1;
        crowbar_trigger_i = 1'b1;
        @(negedge clk_i);
        crowbar_trigger_i = 1'b0;
        `WAITC(crowbar_fire_o, 4)
        hi = 0;
        while (crowbar_fire_o === 1'b1 && hi < CB + 10) begin
            crowbar_trigger_i = (hi == 3);
            @(negedge clk_i);
            hi++;
        end
        `CHK(hi, CB)
    endtask

    initial begin
        repeat (12) @(negedge clk_i);
        rstn_i = 1'b1;
        prog_all(4'hF, 4'hF);
        t_front_end();
        t_inhibit();
        t_triggers();
        t_hard();
        t_off(1'b0, 1'b0);
        t_off(1'b1, 1'b1);
        t_crowbar();
        complete_run();
    end
endmodule

bind gci_group_ctl gci_group_ctl_asserts #(.INH_CYC(INH_CYC), .OFF_LAT_CYC(OFF_LAT_CYC), .CB_CYC(CB_CYC)) u_chk (
    .clk_i(clk_i), .rstn_i(rstn_i), .hotswap_irq_low_i(hotswap_irq_low_i),
    .mains_loss_in_low_i(mains_loss_in_low_i), .system_off_in_low_i(system_off_in_low_i),
    .hard_reset_in_low_i(hard_reset_in_low_i), .irq_mode_i(irq_mode_i), .inhibit_map_i(inhibit_map_i),
    .front_end_on_req_i(front_end_on_req_i), .prog_done_i(prog_done_i), .ok_o(ok_o), .ok_oe_o(ok_oe_o),
    .prog_start_o(prog_start_o), .prog_groups_o(prog_groups_o), .prog_busy_o(prog_busy_o),
    .prog_status_clr_o(prog_status_clr_o), .runtime_save_o(runtime_save_o),
    .front_end_on_o(front_end_on_o), .crowbar_fire_o(crowbar_fire_o));
